// [src/comparator_regs_pkg.sv]
package comparator_regs_pkg;
  localparam logic [11:0] OFS_START_TRIGGER = 12'h000;
  localparam logic [11:0] OFS_STOP_TRIGGER = 12'h004;
  localparam logic [11:0] OFS_SAMPLE_TRIGGER = 12'h008;
  localparam logic [11:0] OFS_START_CHANNEL_LINK = 12'h080;
  localparam logic [11:0] OFS_STOP_CHANNEL_LINK = 12'h084;
  localparam logic [11:0] OFS_SAMPLE_CHANNEL_LINK = 12'h088;
  localparam logic [11:0] OFS_READY_FLAG = 12'h100;
  localparam logic [11:0] OFS_FALLING_FLAG = 12'h104;
  localparam logic [11:0] OFS_RISING_FLAG = 12'h108;
  localparam logic [11:0] OFS_ANY_CROSSING_FLAG = 12'h10C;
  localparam logic [11:0] OFS_READY_CHANNEL_OUT = 12'h180;
  localparam logic [11:0] OFS_FALLING_CHANNEL_OUT = 12'h184;
  localparam logic [11:0] OFS_RISING_CHANNEL_OUT = 12'h188;
  localparam logic [11:0] OFS_CROSSING_CHANNEL_OUT = 12'h18C;
  localparam logic [11:0] OFS_EVENT_TASK_LINKS = 12'h200;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h300;
  localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFS_COMPARE_OUTCOME = 12'h400;
  localparam logic [11:0] OFS_BLOCK_ENABLE = 12'h500;
  localparam logic [11:0] OFS_POSITIVE_INPUT_SELECT = 12'h504;
  localparam logic [11:0] OFS_REFERENCE_SOURCE_SELECT = 12'h508;
  localparam logic [11:0] OFS_EXTERNAL_REFERENCE_PIN = 12'h50C;
  localparam logic [11:0] OFS_HYSTERESIS_THRESHOLDS = 12'h530;
  localparam logic [11:0] OFS_OPERATING_MODE = 12'h534;
  localparam logic [11:0] OFS_HYSTERESIS_ENABLE = 12'h538;
  localparam logic [11:0] OFS_INPUT_CURRENT_SELECT = 12'h53C;
  // Channel link layout
  localparam int LINK_EN_BIT = 31;
  localparam int CHANNEL_INDEX_W = 8;
  localparam logic [31:0] LINK_MASK = 32'h800000FF;
  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  // Event order: ready, falling, rising, crossing
  localparam int EV_READY = 0;
  localparam int EV_FALLING = 1;
  localparam int EV_RISING = 2;
  localparam int EV_CROSSING = 3;
  localparam int NUM_EVENTS = 4;
  // Shortcut bits
  localparam int SC_READY_SAMPLE = 0;
  localparam int SC_READY_STOP = 1;
  localparam int SC_DOWN_STOP = 2;
  localparam int SC_UP_STOP = 3;
  localparam int SC_CROSS_STOP = 4;
  localparam logic [31:0] EVENT_TASK_LINKS_MASK = 32'h0000001F;
  localparam logic [31:0] IRQ_MASK = 32'h0000000F;
  localparam logic [31:0] ENABLE_MASK = 32'h00000003;
  localparam logic [31:0] PSEL_MASK = 32'h00000007;
  localparam logic [31:0] REFERENCE_SOURCE_SELECT_MASK = 32'h00000007;
  localparam logic [31:0] EXTREF_MASK = 32'h00000007;
  localparam logic [31:0] TH_MASK = 32'h00003F3F;
  localparam logic [31:0] MODE_MASK = 32'h00000103;
  localparam logic [31:0] HYSTERESIS_ENABLE_MASK = 32'h00000001;
  localparam logic [31:0] ISRC_MASK = 32'h00000003;
  // Start-to-ready settle time
  localparam int READY_DELAY_NS = 200;
  localparam int CLK_PERIOD_NS = 50;
  localparam int READY_CYCLES = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [src/channel_link.sv]
`timescale 1ns/1ns
`default_nettype none
// One channel link: subscribe match or publish route
module channel_link (
  input wire logic [31:0] cfg,
  input wire logic [255:0] chan_in,
  input wire logic evt,
  output logic hit,
  output logic [255:0] chan_out
);
  wire logic en = cfg[comparator_regs_pkg::LINK_EN_BIT];
  wire logic [7:0] idx = cfg[comparator_regs_pkg::CHANNEL_INDEX_W-1:0];
  assign hit = en & chan_in[idx];
  assign chan_out = (en & evt) ? (256'h1 << idx) : 256'h0;
endmodule
`default_nettype wire

// [src/comparator_task_event_regs.sv]
// Contract
// [RL1] Start subscribe register at 0x080 lets a channel trigger start.
// [RL2] Stop subscribe at 0x084: channel index 0-255, enable bit 31, reset zero.
// [RL3] Sample subscribe at 0x088, same layout, channel fires sample task.
// [RL4] Ready flag at 0x100 sets when comparator ready and output valid.
// [RL5] Crossing flag at 0x10C sets on every output transition; the code sets it only while running after ready.
// [RL6] Publish registers 0x180-0x18C route events onto chosen channels.
// [RL7] Shortcut register 0x200 links events directly to tasks.
// [RL8] Interrupt enable at 0x300, set-only 0x304, clear-only 0x308.
// [RL9] Reference select register at 0x508 for single-ended mode.
// [RL10] Threshold register at 0x530 holds upper and lower thresholds.
// [RL11] Current source select register at 0x53C.
// [RL12] Start leads to ready; sample copies comparator output to result.
// [RL13] Up on upward, down on downward, cross on any crossing; the code raises all three only while running after ready.
// [RL14] Software stops comparator before clearing enable.
// [RL15] Event flags hold until written 0; task writes pulse one clock.
`timescale 1ns/1ns
`default_nettype none
module comparator_task_event_regs (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic comp_out_pin,
  input wire logic [255:0] chan_in,
  output logic [255:0] chan_out,
  output logic irq,
  output logic core_run,
  output logic [1:0] enable_out,
  output logic [2:0] positive_input,
  output logic [2:0] ref_select,
  output logic [2:0] ext_ref,
  output logic [5:0] upper_threshold,
  output logic [5:0] lower_threshold,
  output logic [8:0] mode_out,
  output logic hysteresis_enable_out,
  output logic [1:0] input_current_select_out
);
  ////////////////////////////////////////////////////////////////////
  logic [31:0] sub_r [3];
  logic [31:0] pub_r [4];
  logic [31:0] event_task_links_r, irq_enable_r, enable_r, psel_r, reference_source_select_r, extref_r;
  logic [31:0] th_r, mode_r, hysteresis_enable_r, isrc_r;
  logic [3:0] flag_r;
  logic result_r;
  logic running_r, ready_pend_r;
  logic [7:0] ready_cnt_r;
  logic cmp_s1_r, cmp_s2_r, cmp_prev_r, cmp_valid_r;
  logic [255:0] chan_out_r;
  logic irq_r;

  wire logic wr_start = wr_en && addr == comparator_regs_pkg::OFS_START_TRIGGER && wdata[0];
  wire logic wr_stop = wr_en && addr == comparator_regs_pkg::OFS_STOP_TRIGGER && wdata[0];
  wire logic wr_sample = wr_en && addr == comparator_regs_pkg::OFS_SAMPLE_TRIGGER && wdata[0];

  ////////////////////////////////////////////////////////////////////
  // Subscribe and publish links
  logic [2:0] sub_hit;
  logic [255:0] pub_vec [4];
  logic [3:0] ev_pulse;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sub
      channel_link u_sub (
        .cfg(sub_r[g]),
        .chan_in(chan_in),
        .evt(1'b0),
        .hit(sub_hit[g]),
        .chan_out()
      );
    end
    for (g = 0; g < 4; g++) begin : g_pub
      channel_link u_pub (
        .cfg(pub_r[g]),
        .chan_in(256'h0),
        .evt(ev_pulse[g]),
        .hit(),
        .chan_out(pub_vec[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Event generation
  wire logic cmp_edge = running_r && cmp_valid_r && (cmp_s2_r != cmp_prev_r);
  wire logic ready_done = running_r && ready_pend_r &&
    ready_cnt_r == 8'(comparator_regs_pkg::READY_CYCLES);
  assign ev_pulse[comparator_regs_pkg::EV_READY] = ready_done; // RL4 RL12
  assign ev_pulse[comparator_regs_pkg::EV_FALLING] = cmp_edge && !cmp_s2_r; // RL13
  assign ev_pulse[comparator_regs_pkg::EV_RISING] = cmp_edge && cmp_s2_r; // RL13
  assign ev_pulse[comparator_regs_pkg::EV_CROSSING] = cmp_edge; // RL5 RL13

  // Tasks: software, subscription, shortcut
  wire logic task_start = wr_start | sub_hit[0]; // RL1 RL15
  wire logic task_stop = wr_stop | sub_hit[1] | // RL2
    (ev_pulse[comparator_regs_pkg::EV_READY] & event_task_links_r[comparator_regs_pkg::SC_READY_STOP]) |
    (ev_pulse[comparator_regs_pkg::EV_FALLING] & event_task_links_r[comparator_regs_pkg::SC_DOWN_STOP]) |
    (ev_pulse[comparator_regs_pkg::EV_RISING] & event_task_links_r[comparator_regs_pkg::SC_UP_STOP]) |
    (ev_pulse[comparator_regs_pkg::EV_CROSSING] & event_task_links_r[comparator_regs_pkg::SC_CROSS_STOP]);
  wire logic task_sample = wr_sample | sub_hit[2] | // RL3 RL7
    (ev_pulse[comparator_regs_pkg::EV_READY] & event_task_links_r[comparator_regs_pkg::SC_READY_SAMPLE]);
  wire logic enabled = enable_r[1:0] != 2'h0;
  wire logic [255:0] pub_all = pub_vec[0] | pub_vec[1] | pub_vec[2] | pub_vec[3]; // RL6

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser and core sequencing
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      cmp_s1_r <= comp_out_pin;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      running_r <= 1'b0;
      ready_pend_r <= 1'b0;
      ready_cnt_r <= 8'h00;
      cmp_prev_r <= 1'b0;
      cmp_valid_r <= 1'b0;
      result_r <= 1'b0;
    end else begin
      cmp_prev_r <= cmp_s2_r;
      if (task_stop || !enabled) begin
        // Stop wins over a same-cycle start
        running_r <= 1'b0;
        ready_pend_r <= 1'b0;
        cmp_valid_r <= 1'b0;
      end else if (task_start && !running_r) begin
        running_r <= 1'b1;
        ready_pend_r <= 1'b1;
        ready_cnt_r <= 8'h00;
      end else if (ready_pend_r) begin
        ready_cnt_r <= ready_cnt_r + 8'h01;
        if (ready_done) begin
          ready_pend_r <= 1'b0;
          cmp_valid_r <= 1'b1;
        end
      end
      if (task_sample) begin
        result_r <= cmp_s2_r; // RL12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register writes
  wire logic [3:0] flag_wr;
  generate
    for (g = 0; g < 4; g++) begin : g_fw
      assign flag_wr[g] = wr_en && addr == 12'(comparator_regs_pkg::OFS_READY_FLAG + 12'(4 * g));
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flag_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // Event set wins over software clear
        if (ev_pulse[i]) begin
          flag_r[i] <= 1'b1; // RL4 RL5 RL15
        end else if (flag_wr[i]) begin
          flag_r[i] <= wdata[0]; // RL15
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) sub_r[i] <= comparator_regs_pkg::RESET_VALUE; // RL2
      for (int i = 0; i < 4; i++) pub_r[i] <= comparator_regs_pkg::RESET_VALUE;
      event_task_links_r <= comparator_regs_pkg::RESET_VALUE;
      irq_enable_r <= comparator_regs_pkg::RESET_VALUE;
      enable_r <= comparator_regs_pkg::RESET_VALUE;
      psel_r <= comparator_regs_pkg::RESET_VALUE;
      reference_source_select_r <= comparator_regs_pkg::RESET_VALUE;
      extref_r <= comparator_regs_pkg::RESET_VALUE;
      th_r <= comparator_regs_pkg::RESET_VALUE;
      mode_r <= comparator_regs_pkg::RESET_VALUE;
      hysteresis_enable_r <= comparator_regs_pkg::RESET_VALUE;
      isrc_r <= comparator_regs_pkg::RESET_VALUE;
    end else if (wr_en) begin
      case (addr)
        comparator_regs_pkg::OFS_START_CHANNEL_LINK:
          sub_r[0] <= wdata & comparator_regs_pkg::LINK_MASK; // RL1
        comparator_regs_pkg::OFS_STOP_CHANNEL_LINK:
          sub_r[1] <= wdata & comparator_regs_pkg::LINK_MASK; // RL2
        comparator_regs_pkg::OFS_SAMPLE_CHANNEL_LINK:
          sub_r[2] <= wdata & comparator_regs_pkg::LINK_MASK; // RL3
        comparator_regs_pkg::OFS_READY_CHANNEL_OUT:
          pub_r[0] <= wdata & comparator_regs_pkg::LINK_MASK; // RL6
        comparator_regs_pkg::OFS_FALLING_CHANNEL_OUT:
          pub_r[1] <= wdata & comparator_regs_pkg::LINK_MASK;
        comparator_regs_pkg::OFS_RISING_CHANNEL_OUT:
          pub_r[2] <= wdata & comparator_regs_pkg::LINK_MASK;
        comparator_regs_pkg::OFS_CROSSING_CHANNEL_OUT:
          pub_r[3] <= wdata & comparator_regs_pkg::LINK_MASK;
        comparator_regs_pkg::OFS_EVENT_TASK_LINKS:
          event_task_links_r <= wdata & comparator_regs_pkg::EVENT_TASK_LINKS_MASK; // RL7
        comparator_regs_pkg::OFS_IRQ_ENABLE:
          irq_enable_r <= wdata & comparator_regs_pkg::IRQ_MASK; // RL8
        comparator_regs_pkg::OFS_IRQ_ENABLE_SET:
          irq_enable_r <= irq_enable_r | (wdata & comparator_regs_pkg::IRQ_MASK); // RL8
        comparator_regs_pkg::OFS_IRQ_ENABLE_CLEAR:
          irq_enable_r <= irq_enable_r & ~wdata; // RL8
        // Software must stop the core first; clearing anyway stops it
        comparator_regs_pkg::OFS_BLOCK_ENABLE:
          enable_r <= wdata & comparator_regs_pkg::ENABLE_MASK; // RL14
        comparator_regs_pkg::OFS_POSITIVE_INPUT_SELECT:
          psel_r <= wdata & comparator_regs_pkg::PSEL_MASK;
        comparator_regs_pkg::OFS_REFERENCE_SOURCE_SELECT:
          reference_source_select_r <= wdata & comparator_regs_pkg::REFERENCE_SOURCE_SELECT_MASK; // RL9
        comparator_regs_pkg::OFS_EXTERNAL_REFERENCE_PIN:
          extref_r <= wdata & comparator_regs_pkg::EXTREF_MASK;
        comparator_regs_pkg::OFS_HYSTERESIS_THRESHOLDS:
          th_r <= wdata & comparator_regs_pkg::TH_MASK; // RL10
        comparator_regs_pkg::OFS_OPERATING_MODE:
          mode_r <= wdata & comparator_regs_pkg::MODE_MASK;
        comparator_regs_pkg::OFS_HYSTERESIS_ENABLE:
          hysteresis_enable_r <= wdata & comparator_regs_pkg::HYSTERESIS_ENABLE_MASK;
        comparator_regs_pkg::OFS_INPUT_CURRENT_SELECT:
          isrc_r <= wdata & comparator_regs_pkg::ISRC_MASK; // RL11
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; tasks and unmapped read as zero
  logic [31:0] rd_mux;
  always_comb begin
    case (addr)
      comparator_regs_pkg::OFS_START_CHANNEL_LINK: rd_mux = sub_r[0];
      comparator_regs_pkg::OFS_STOP_CHANNEL_LINK: rd_mux = sub_r[1];
      comparator_regs_pkg::OFS_SAMPLE_CHANNEL_LINK: rd_mux = sub_r[2];
      comparator_regs_pkg::OFS_READY_FLAG: rd_mux = {31'h0, flag_r[0]};
      comparator_regs_pkg::OFS_FALLING_FLAG: rd_mux = {31'h0, flag_r[1]};
      comparator_regs_pkg::OFS_RISING_FLAG: rd_mux = {31'h0, flag_r[2]};
      comparator_regs_pkg::OFS_ANY_CROSSING_FLAG: rd_mux = {31'h0, flag_r[3]};
      comparator_regs_pkg::OFS_READY_CHANNEL_OUT: rd_mux = pub_r[0];
      comparator_regs_pkg::OFS_FALLING_CHANNEL_OUT: rd_mux = pub_r[1];
      comparator_regs_pkg::OFS_RISING_CHANNEL_OUT: rd_mux = pub_r[2];
      comparator_regs_pkg::OFS_CROSSING_CHANNEL_OUT: rd_mux = pub_r[3];
      comparator_regs_pkg::OFS_EVENT_TASK_LINKS: rd_mux = event_task_links_r;
      comparator_regs_pkg::OFS_IRQ_ENABLE: rd_mux = irq_enable_r;
      comparator_regs_pkg::OFS_IRQ_ENABLE_SET: rd_mux = irq_enable_r;
      comparator_regs_pkg::OFS_IRQ_ENABLE_CLEAR: rd_mux = irq_enable_r;
      comparator_regs_pkg::OFS_COMPARE_OUTCOME: rd_mux = {31'h0, result_r};
      comparator_regs_pkg::OFS_BLOCK_ENABLE: rd_mux = enable_r;
      comparator_regs_pkg::OFS_POSITIVE_INPUT_SELECT: rd_mux = psel_r;
      comparator_regs_pkg::OFS_REFERENCE_SOURCE_SELECT: rd_mux = reference_source_select_r;
      comparator_regs_pkg::OFS_EXTERNAL_REFERENCE_PIN: rd_mux = extref_r;
      comparator_regs_pkg::OFS_HYSTERESIS_THRESHOLDS: rd_mux = th_r;
      comparator_regs_pkg::OFS_OPERATING_MODE: rd_mux = mode_r;
      comparator_regs_pkg::OFS_HYSTERESIS_ENABLE: rd_mux = hysteresis_enable_r;
      comparator_regs_pkg::OFS_INPUT_CURRENT_SELECT: rd_mux = isrc_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
      chan_out_r <= 256'h0;
      irq_r <= 1'b0;
    end else begin
      rdata <= rd_en ? rd_mux : 32'h00000000;
      chan_out_r <= pub_all; // RL6
      irq_r <= |(flag_r & irq_enable_r[3:0]);
    end
  end

  assign chan_out = chan_out_r;
  assign irq = irq_r;
  assign core_run = running_r;
  assign enable_out = enable_r[1:0];
  assign positive_input = psel_r[2:0];
  assign ref_select = reference_source_select_r[2:0];
  assign ext_ref = extref_r[2:0];
  assign upper_threshold = th_r[13:8];
  assign lower_threshold = th_r[5:0];
  assign mode_out = mode_r[8:0];
  assign hysteresis_enable_out = hysteresis_enable_r[0];
  assign input_current_select_out = isrc_r[1:0];

  ////////////////////////////////////////////////////////////////////
  property p_flag_set;
    @(posedge clk_sys) disable iff (!resetn)
      ev_pulse[comparator_regs_pkg::EV_CROSSING] |=> flag_r[comparator_regs_pkg::EV_CROSSING];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("cross flag not set"); // RL5
  property p_ready_after_start;
    @(posedge clk_sys) disable iff (!resetn)
      (task_start && !running_r && !task_stop && enabled) ##1 (running_r && !task_stop && enabled)[*5]
      |=> flag_r[comparator_regs_pkg::EV_READY];
  endproperty
  a_ready_after_start: assert property (p_ready_after_start) else $error("no ready"); // RL4
  property p_flag_hold;
    @(posedge clk_sys) disable iff (!resetn)
      (flag_r[0] && !(flag_wr[0] && !wdata[0])) |=> flag_r[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost"); // RL15
  property p_sample;
    @(posedge clk_sys) disable iff (!resetn) wr_sample |=> result_r == $past(cmp_s2_r);
  endproperty
  a_sample: assert property (p_sample) else $error("sample wrong"); // RL12
  property p_up;
    @(posedge clk_sys) disable iff (!resetn)
      ($rose(cmp_s2_r) && running_r && cmp_valid_r) |=>
        (flag_r[comparator_regs_pkg::EV_RISING] && flag_r[comparator_regs_pkg::EV_CROSSING]);
  endproperty
  a_up: assert property (p_up) else $error("bad up"); // RL13
  property p_sub_stop;
    @(posedge clk_sys) disable iff (!resetn) sub_hit[1] |=> !running_r;
  endproperty
  a_sub_stop: assert property (p_sub_stop) else $error("stop ignored"); // RL2
  property p_irq_enable_set;
    @(posedge clk_sys) disable iff (!resetn)
      (wr_en && addr == comparator_regs_pkg::OFS_IRQ_ENABLE_SET) |=> (irq_enable_r & $past(wdata[3:0])) == $past(wdata[3:0]);
  endproperty
  a_irq_enable_set: assert property (p_irq_enable_set) else $error("set failed"); // RL8
  property p_irq;
    @(posedge clk_sys) disable iff (!resetn) |(flag_r & irq_enable_r[3:0]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // RL8
  property p_pub;
    @(posedge clk_sys) disable iff (!resetn)
      (ev_pulse[0] && pub_r[0][31]) |=> chan_out[$past(pub_r[0][7:0])];
  endproperty
  a_pub: assert property (p_pub) else $error("publish missing"); // RL6
  c_ready: cover property (@(posedge clk_sys) ev_pulse[0]);
  c_cross: cover property (@(posedge clk_sys) ev_pulse[3]);
  c_irq: cover property (@(posedge clk_sys) irq);
endmodule
`default_nettype wire

// [verification/interconnect_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Far side stand-in: one-cycle channel pulses and a held comparator level
module interconnect_model (
  input wire logic clk_sys,
  input wire logic [255:0] chan_out,
  output logic [255:0] chan_in,
  output logic comp_out_pin
);
  int pub_count [256];
  initial begin
    chan_in = '0;
    comp_out_pin = 1'b0;
    foreach (pub_count[i]) pub_count[i] = 0;
  end
  // Publish pulses last one cycle, so each high cycle is one event
  always @(posedge clk_sys) begin
    for (int i = 0; i < 256; i++) begin
      if (chan_out[i] === 1'b1) begin
        pub_count[i] <= pub_count[i] + 1;
      end
    end
  end
  task automatic fire(input int ch);
    @(posedge clk_sys);
    chan_in[ch] <= 1'b1;
    @(posedge clk_sys);
    chan_in[ch] <= 1'b0;
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    comp_out_pin <= v;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic [255:0] chan_in;
  logic [255:0] chan_out;
  logic comp_out_pin;
  logic irq;
  logic core_run;
  logic [2:0] ref_select;
  logic [5:0] upper_threshold;
  logic [5:0] lower_threshold;
  logic [1:0] input_current_select_out;
  logic [1:0] enable_out;
  logic [2:0] positive_input;
  logic [2:0] ext_ref;
  logic [8:0] mode_out;
  logic hysteresis_enable_out;
  int err_count = 0;
  int cmp_count = 0;

  always #25 clk_sys = ~clk_sys;

  comparator_task_event_regs comparator_task_event_regs_inst (
    .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .comp_out_pin(comp_out_pin), .chan_in(chan_in),
    .chan_out(chan_out), .irq(irq), .core_run(core_run), .enable_out(enable_out),
    .positive_input(positive_input), .ref_select(ref_select), .ext_ref(ext_ref),
    .upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
    .mode_out(mode_out), .hysteresis_enable_out(hysteresis_enable_out), .input_current_select_out(input_current_select_out)
  );

  interconnect_model interconnect_model_inst (
    .clk_sys(clk_sys), .chan_out(chan_out), .chan_in(chan_in),
    .comp_out_pin(comp_out_pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check($sformatf("reg %h", a), d, e);
  endtask

  // Bounded wait on a register value, then compare
  task automatic poll(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    for (int i = 0; i < 30; i++) begin
      rd(a, d);
      if (d === e) break;
    end
    check($sformatf("poll %h", a), d, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 4000);
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    chk_rd(12'h084, 32'h00000000);
    chk_rd(12'h088, 32'h00000000);
    chk_rd(12'h100, 32'h00000000);
    chk_rd(12'h10C, 32'h00000000);
    // Only index and enable bits are kept
    wr(12'h084, 32'hFFFFFFFF);
    chk_rd(12'h084, 32'h800000FF);
    wr(12'h080, 32'h7FFFFF05);
    chk_rd(12'h080, 32'h00000005);
    wr(12'h508, 32'hFFFFFFFF);
    chk_rd(12'h508, 32'h00000007);
    check("ref_select", {29'h0, ref_select}, 32'h00000007);
    wr(12'h530, 32'hFFFF2A15);
    chk_rd(12'h530, 32'h00002A15);
    check("upper", {26'h0, upper_threshold}, 32'h0000002A);
    check("lower", {26'h0, lower_threshold}, 32'h00000015);
    wr(12'h53C, 32'hFFFFFFFF);
    chk_rd(12'h53C, 32'h00000003);
    check("input_current_select", {30'h0, input_current_select_out}, 32'h00000003);
    wr(12'h504, 32'hFFFFFFFF);
    wr(12'h50C, 32'hFFFFFFFF);
    wr(12'h534, 32'hFFFFFFFF);
    wr(12'h538, 32'hFFFFFFFF);
    chk_rd(12'h534, 32'h00000103);
    check("psel", {29'h0, positive_input}, 32'h00000007);
    check("extref", {29'h0, ext_ref}, 32'h00000007);
    check("mode", {23'h0, mode_out}, 32'h00000103);
    check("hysteresis_enable", {31'h0, hysteresis_enable_out}, 32'h00000001);
    chk_rd(12'h0FC, 32'h00000000);
    wr(12'h300, 32'hFFFFFFFF);
    chk_rd(12'h300, 32'h0000000F);
    wr(12'h308, 32'h00000001);
    chk_rd(12'h300, 32'h0000000E);
    wr(12'h304, 32'h00000001);
    chk_rd(12'h300, 32'h0000000F);
    // Start from channel 5, ready published on channel 16
    wr(12'h180, 32'h80000010);
    wr(12'h080, 32'h80000005);
    wr(12'h500, 32'h00000001);
    chk_rd(12'h500, 32'h00000001);
    check("enable", {30'h0, enable_out}, 32'h00000001);
    interconnect_model_inst.fire(4);
    settle(2);
    check("run idle", {31'h0, core_run}, 32'h00000000);
    interconnect_model_inst.fire(5);
    settle(2);
    check("run", {31'h0, core_run}, 32'h00000001);
    poll(12'h100, 32'h00000001);
    settle(2);
    check("irq set", {31'h0, irq}, 32'h00000001);
    check("publish", interconnect_model_inst.pub_count[16], 32'h00000001);
    // Flag holds until written zero; irq follows
    wr(12'h100, 32'h00000000);
    settle(2);
    check("irq clr", {31'h0, irq}, 32'h00000000);
    chk_rd(12'h100, 32'h00000000);
    chk_rd(12'h000, 32'h00000000);
    // Crossing events published on channel 32
    wr(12'h18C, 32'h80000020);
    interconnect_model_inst.set_pin(1'b1);
    poll(12'h108, 32'h00000001);
    chk_rd(12'h10C, 32'h00000001);
    chk_rd(12'h104, 32'h00000000);
    wr(12'h10C, 32'h00000000);
    interconnect_model_inst.set_pin(1'b0);
    poll(12'h104, 32'h00000001);
    chk_rd(12'h10C, 32'h00000001);
    check("publish cross", interconnect_model_inst.pub_count[32], 32'h00000002);
    wr(12'h008, 32'h00000001);
    chk_rd(12'h400, 32'h00000000);
    interconnect_model_inst.set_pin(1'b1);
    settle(4);
    wr(12'h088, 32'h80000009);
    interconnect_model_inst.fire(9);
    chk_rd(12'h400, 32'h00000001);
    // Stop on channel 200; a neighbouring channel must not stop it
    wr(12'h084, 32'h800000C8);
    interconnect_model_inst.fire(201);
    settle(2);
    check("run kept", {31'h0, core_run}, 32'h00000001);
    interconnect_model_inst.fire(200);
    settle(2);
    check("run stop", {31'h0, core_run}, 32'h00000000);
    wr(12'h100, 32'h00000000);
    // Pin moved while stopped, so the ready sample must read 0
    interconnect_model_inst.set_pin(1'b0);
    wr(12'h200, 32'h00000003);
    chk_rd(12'h200, 32'h00000003);
    wr(12'h000, 32'h00000001);
    poll(12'h100, 32'h00000001);
    settle(2);
    check("short stop", {31'h0, core_run}, 32'h00000000);
    chk_rd(12'h400, 32'h00000000);
    // Crossing shortcut stops a running core
    wr(12'h100, 32'h00000000);
    wr(12'h200, 32'h00000010);
    wr(12'h000, 32'h00000001);
    poll(12'h100, 32'h00000001);
    interconnect_model_inst.set_pin(1'b1);
    settle(4);
    check("cross stop", {31'h0, core_run}, 32'h00000000);
    // Core already stopped before disabling
    wr(12'h500, 32'h00000000);
    chk_rd(12'h500, 32'h00000000);
    check("enable off", {30'h0, enable_out}, 32'h00000000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
